// ==== warmup_params.svh ====
`ifndef WARMUP_PARAMS_SVH
`define WARMUP_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define WU_OFS_CTRL 5'h00
`define WU_OFS_TIME 5'h04
`define WU_OFS_SYS2 5'h08
`define WU_OFS_STATUS 5'h0C
`define WU_OFS_IRQ_STAT 5'h10
`define WU_OFS_IRQ_MASK 5'h14

// Field positions of warmup_control_reg
`define WU_CTRL_SRC_BIT 0
`define WU_CTRL_DIV_LO 1
`define WU_CTRL_DIV_HI 2
`define WU_CTRL_ABORT_BIT 3

// Field positions of system_control_two
`define WU_SYS2_HF_EN_BIT 0
`define WU_SYS2_LF_EN_BIT 1
`define WU_SYS2_CLKSEL_BIT 2

// Field positions of the status and interrupt registers
`define WU_STAT_SW_BIT 16
`define WU_STAT_STOP_BIT 17
`define WU_IRQ_SW_DONE_BIT 0
`define WU_IRQ_STOP_DONE_BIT 1

// Reset values
`define WU_RST_SRC 1'b0
`define WU_RST_DIV 2'h3
`define WU_RST_TIME 8'h66
`define WU_RST_HF_EN 1'b1
`define WU_RST_LF_EN 1'b0
`define WU_RST_CLKSEL 1'b0
`define WU_RST_MASK 2'h0

// Counter geometry
`define WU_CNT_W 14
`define WU_DIV_W 3
`define WU_MATCH_LO 6

`endif

// ==== warmup_pkg.sv ====
package warmup_pkg;

   // Warm-up engine states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SW_COUNT = 4'b0010,
      ST_STOP_HOLD = 4'b0100,
      ST_STOP_COUNT = 4'b1000
   } warmup_state_type;

   // Divide selection code
   typedef logic [1:0] div_sel_type;

endpackage

// ==== osc_edge_sync.sv ====
`timescale 1ns/1ps

module osc_edge_sync (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Raw oscillator pin
   input wire logic osc_pin_in,
   // One-cycle pulse per rising oscillator edge
   output logic edge_pulse_out
);

   logic meta_ff; // First stage, read only by sync_ff
   logic sync_ff; // Second stage, safe to use
   logic last_ff; // Delayed copy for edge detection

   // Two-flop synchroniser plus history stage
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= osc_pin_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   // Registered rising-edge pulse; the oscillator must run
   // below half of the system clock or edges are lost
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         edge_pulse_out <= 1'b0;
      end else begin
         edge_pulse_out <= sync_ff & ~last_ff;
      end
   end

endmodule // osc_edge_sync

// ==== oscillator_warmup_counter.sv ====
`timescale 1ns/1ps
`include "warmup_params.svh"
// Behaviour
// - STOP release counts clock used at entry
// - Release starts 14-stage counter on divided clock
// - Upper byte match halts, CPU resumes
// - Divide select: 1, 2, 4, 8
// - STOP during software warm-up holds count
// - Source select: 0 high, 1 low
// - Enable bit rise starts oscillator and counter
// - Only 0-to-1 enable change starts counting
// - Software match: interrupt, stop, clear
// - Abort stops, clears, self-clears
// - Abort keeps enable bits unchanged
// - Selector, 3-stage divider, 14-stage counter
// - Reset: high source, divide by 8
// - Reset: warm-up setting 0x66

module oscillator_warmup_counter (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Raw oscillator outputs
   input wire logic high_freq_clock_in,
   input wire logic low_freq_clock_in,
   // Power-mode control, same clock domain
   input wire logic stop_enter_in,
   input wire logic stop_release_in,
   // Oscillator and system controls
   output logic hf_osc_run_out,
   output logic lf_osc_run_out,
   output logic main_clock_lf_out,
   output logic stop_mode_out,
   output logic cpu_resume_out,
   output logic warmup_done_interrupt_out
);

   // Upper counter byte against the setting
   function automatic logic upper_match(
      input logic [`WU_CNT_W-1:0] cnt,
      input logic [7:0] setting
   );
      return cnt[`WU_CNT_W-1:`WU_MATCH_LO] == setting;
   endfunction

   // Divided tick out of the 3-stage divider
   function automatic logic div_tick_f(
      input warmup_pkg::div_sel_type sel,
      input logic [`WU_DIV_W-1:0] div,
      input logic tick
   );
      logic res;
      res = 1'b0;
      case (sel)
         2'h0: res = tick;
         2'h1: res = tick & div[0];
         2'h2: res = tick & (&div[1:0]);
         default: res = tick & (&div);
      endcase
      return res;
   endfunction

   // Register state
   logic src_sel_ff; // Software source select
   warmup_pkg::div_sel_type div_sel_ff; // Divide selection
   logic [7:0] time_set_ff; // Warm-up setting
   logic hf_en_ff; // High-frequency enable
   logic lf_en_ff; // Low-frequency enable
   logic clksel_ff; // Main clock from low source
   logic [1:0] irq_stat_ff; // Sticky events
   logic [1:0] irq_mask_ff; // Interrupt mask
   logic [31:0] readdata_ff; // Bus read data
   logic waitrequest_ff; // Bus wait, low for answer

   // Warm-up engine state
   warmup_pkg::warmup_state_type state_ff;
   logic [`WU_CNT_W-1:0] cnt_ff; // 14-stage counter
   logic [`WU_DIV_W-1:0] div_ff; // 3-stage divider
   logic stop_src_ff; // Source latched at STOP entry
   logic sw_pend_ff; // Software warm-up suspended by STOP
   logic stop_mode_ff; // STOP or its warm-up active
   logic resume_ff; // Resume pulse
   logic hf_run_ff; // High oscillator running
   logic lf_run_ff; // Low oscillator running
   logic irq_ff; // Interrupt level

   // Oscillator edge pulses
   logic hf_tick;
   logic lf_tick;

   // Per-cycle decode
   logic taken; // Request answered this edge
   logic wr_ctrl;
   logic wr_time;
   logic wr_sys2;
   logic wr_stat;
   logic wr_mask;
   logic sw_start; // Enable bit rose
   logic abort; // Abort written
   logic counting;
   logic src_sel; // Live divider source
   logic src_tick;
   logic div_tick;
   logic hit; // Counter reached setting
   logic sw_done_evt;
   logic stop_done_evt;
   logic [1:0] nxt_irq_stat;
   logic [31:0] nxt_readdata;

   // Oscillator pins cross into the system clock here
   osc_edge_sync u_hf_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .osc_pin_in(high_freq_clock_in),
      .edge_pulse_out(hf_tick)
   );

   osc_edge_sync u_lf_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .osc_pin_in(low_freq_clock_in),
      .edge_pulse_out(lf_tick)
   );

   // Write strobes; all writable fields live in byte lane 0
   always_comb begin
      taken = (avs_read_in | avs_write_in) & ~waitrequest_ff;
      wr_ctrl = 1'b0;
      wr_time = 1'b0;
      wr_sys2 = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (taken && avs_write_in && avs_byteenable_in[0]) begin
         case (avs_address_in)
            `WU_OFS_CTRL: wr_ctrl = 1'b1;
            `WU_OFS_TIME: wr_time = 1'b1;
            `WU_OFS_SYS2: wr_sys2 = 1'b1;
            `WU_OFS_IRQ_STAT: wr_stat = 1'b1;
            `WU_OFS_IRQ_MASK: wr_mask = 1'b1;
            default: wr_ctrl = 1'b0; // Unmapped or read-only STATUS: ignored
         endcase
      end
   end

   // Start and abort events
   always_comb begin
      // Rewriting a one leaves the edge low
      sw_start = wr_sys2 & (
         (avs_writedata_in[`WU_SYS2_HF_EN_BIT] & ~hf_en_ff) |
         (avs_writedata_in[`WU_SYS2_LF_EN_BIT] & ~lf_en_ff));
      abort = wr_ctrl & avs_writedata_in[`WU_CTRL_ABORT_BIT];
   end

   // Source selector, divider tick and compare
   always_comb begin
      counting = (state_ff == warmup_pkg::ST_SW_COUNT) ||
                 (state_ff == warmup_pkg::ST_STOP_COUNT);
      // STOP warm-up ignores the software select
      if (state_ff == warmup_pkg::ST_STOP_COUNT) begin
         src_sel = stop_src_ff;
      end else begin
         src_sel = src_sel_ff;
      end
      src_tick = src_sel ? lf_tick : hf_tick;
      div_tick = div_tick_f(div_sel_ff, div_ff, src_tick);
      hit = counting & upper_match(cnt_ff, time_set_ff);
      sw_done_evt = ((state_ff == warmup_pkg::ST_SW_COUNT) & hit &
                     ~stop_enter_in & ~abort) |
                    ((state_ff == warmup_pkg::ST_STOP_COUNT) & hit &
                     sw_pend_ff);
      stop_done_evt = (state_ff == warmup_pkg::ST_STOP_COUNT) & hit;
   end

   // Configuration registers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_sel_ff <= `WU_RST_SRC;
         div_sel_ff <= `WU_RST_DIV;
         time_set_ff <= `WU_RST_TIME;
         irq_mask_ff <= `WU_RST_MASK;
      end else begin
         // Taken live; software sets them before STOP
         if (wr_ctrl) begin
            src_sel_ff <= avs_writedata_in[`WU_CTRL_SRC_BIT];
            div_sel_ff <=
               avs_writedata_in[`WU_CTRL_DIV_HI:`WU_CTRL_DIV_LO];
         end
         if (wr_time) begin
            time_set_ff <= avs_writedata_in[7:0];
         end
         if (wr_mask) begin
            irq_mask_ff <= avs_writedata_in[1:0];
         end
      end
   end

   // Oscillator enables; abort never touches them
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hf_en_ff <= `WU_RST_HF_EN;
         lf_en_ff <= `WU_RST_LF_EN;
         clksel_ff <= `WU_RST_CLKSEL;
      end else if (wr_sys2) begin
         hf_en_ff <= avs_writedata_in[`WU_SYS2_HF_EN_BIT];
         lf_en_ff <= avs_writedata_in[`WU_SYS2_LF_EN_BIT];
         clksel_ff <= avs_writedata_in[`WU_SYS2_CLKSEL_BIT];
      end
   end

   // Warm-up engine
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= warmup_pkg::ST_IDLE;
         cnt_ff <= '0;
         div_ff <= '0;
         stop_src_ff <= 1'b0;
         sw_pend_ff <= 1'b0;
         stop_mode_ff <= 1'b0;
      end else begin
         case (state_ff)
            // Waiting for an enable edge or STOP
            warmup_pkg::ST_IDLE: begin
               if (stop_enter_in) begin
                  state_ff <= warmup_pkg::ST_STOP_HOLD;
                  stop_src_ff <= clksel_ff;
                  sw_pend_ff <= 1'b0;
                  stop_mode_ff <= 1'b1;
               end else if (sw_start) begin
                  state_ff <= warmup_pkg::ST_SW_COUNT;
                  cnt_ff <= '0;
                  div_ff <= '0;
               end
            end
            // Software-started warm-up
            warmup_pkg::ST_SW_COUNT: begin
               if (stop_enter_in) begin
                  // Count kept; resumed warm-up falls short
                  state_ff <= warmup_pkg::ST_STOP_HOLD;
                  stop_src_ff <= clksel_ff;
                  sw_pend_ff <= 1'b1;
                  stop_mode_ff <= 1'b1;
               end else if (abort || hit) begin
                  state_ff <= warmup_pkg::ST_IDLE;
                  cnt_ff <= '0;
                  div_ff <= '0;
               end else if (sw_start) begin
                  cnt_ff <= '0; // Second oscillator restarts
                  div_ff <= '0;
               end else if (src_tick) begin
                  div_ff <= div_ff + 3'h1;
                  if (div_tick) begin
                     cnt_ff <= cnt_ff + 14'h0001;
                  end
               end
            end
            // Oscillators stopped, count frozen
            warmup_pkg::ST_STOP_HOLD: begin
               if (stop_release_in) begin
                  state_ff <= warmup_pkg::ST_STOP_COUNT;
                  div_ff <= '0;
               end
            end
            // Hardware warm-up after STOP release
            warmup_pkg::ST_STOP_COUNT: begin
               if (hit) begin
                  state_ff <= warmup_pkg::ST_IDLE;
                  cnt_ff <= '0;
                  div_ff <= '0;
                  sw_pend_ff <= 1'b0;
                  stop_mode_ff <= 1'b0;
               end else if (src_tick) begin
                  div_ff <= div_ff + 3'h1;
                  if (div_tick) begin
                     cnt_ff <= cnt_ff + 14'h0001;
                  end
               end
            end
            default: begin
               state_ff <= warmup_pkg::ST_IDLE;
               cnt_ff <= '0;
               div_ff <= '0;
               stop_mode_ff <= 1'b0;
            end
         endcase
      end
   end

   // Resume pulse and oscillator run lines
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         resume_ff <= 1'b0;
         hf_run_ff <= 1'b0;
         lf_run_ff <= 1'b0;
      end else begin
         resume_ff <= stop_done_evt;
         // STOP halts every oscillator until release
         hf_run_ff <= hf_en_ff & (state_ff != warmup_pkg::ST_STOP_HOLD);
         lf_run_ff <= lf_en_ff & (state_ff != warmup_pkg::ST_STOP_HOLD);
      end
   end

   // Sticky events; a set beats a same-cycle clear
   always_comb begin
      nxt_irq_stat = irq_stat_ff;
      if (wr_stat) begin
         nxt_irq_stat = irq_stat_ff & ~avs_writedata_in[1:0];
      end
      nxt_irq_stat[`WU_IRQ_SW_DONE_BIT] =
         nxt_irq_stat[`WU_IRQ_SW_DONE_BIT] | sw_done_evt;
      nxt_irq_stat[`WU_IRQ_STOP_DONE_BIT] =
         nxt_irq_stat[`WU_IRQ_STOP_DONE_BIT] | stop_done_evt;
   end

   // Interrupt status and output level
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // Read mux; abort reads zero since it never holds
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      case (avs_address_in)
         `WU_OFS_CTRL: begin
            nxt_readdata[`WU_CTRL_SRC_BIT] = src_sel_ff;
            nxt_readdata[`WU_CTRL_DIV_HI:`WU_CTRL_DIV_LO] = div_sel_ff;
         end
         `WU_OFS_TIME: nxt_readdata[7:0] = time_set_ff;
         `WU_OFS_SYS2: begin
            nxt_readdata[`WU_SYS2_HF_EN_BIT] = hf_en_ff;
            nxt_readdata[`WU_SYS2_LF_EN_BIT] = lf_en_ff;
            nxt_readdata[`WU_SYS2_CLKSEL_BIT] = clksel_ff;
         end
         `WU_OFS_STATUS: begin
            nxt_readdata[`WU_CNT_W-1:0] = cnt_ff;
            nxt_readdata[`WU_STAT_SW_BIT] =
               (state_ff == warmup_pkg::ST_SW_COUNT) | sw_pend_ff;
            nxt_readdata[`WU_STAT_STOP_BIT] = stop_mode_ff;
         end
         `WU_OFS_IRQ_STAT: nxt_readdata[1:0] = irq_stat_ff;
         `WU_OFS_IRQ_MASK: nxt_readdata[1:0] = irq_mask_ff;
         default: nxt_readdata = 32'h0000_0000;
      endcase
   end

   // Bus answer: wait drops for one cycle after each request
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitrequest_ff <= 1'b1;
         readdata_ff <= 32'h0000_0000;
      end else if ((avs_read_in || avs_write_in) && waitrequest_ff) begin
         waitrequest_ff <= 1'b0;
         readdata_ff <= avs_read_in ? nxt_readdata : 32'h0000_0000;
      end else begin
         waitrequest_ff <= 1'b1;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_out = readdata_ff;
   assign avs_waitrequest_out = waitrequest_ff;
   assign hf_osc_run_out = hf_run_ff;
   assign lf_osc_run_out = lf_run_ff;
   assign main_clock_lf_out = clksel_ff;
   assign stop_mode_out = stop_mode_ff;
   assign cpu_resume_out = resume_ff;
   assign warmup_done_interrupt_out = irq_ff;

   // Checks on the engine
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // Entry must latch the clock feeding the system, not the select
   property p_stop_source;
      (state_ff == warmup_pkg::ST_IDLE ||
         state_ff == warmup_pkg::ST_SW_COUNT) && stop_enter_in |=>
         stop_src_ff == $past(clksel_ff);
   endproperty
   a_stop_source: assert property (p_stop_source)
      else $error("STOP warm-up uses wrong source");

   property p_stop_count;
      state_ff == warmup_pkg::ST_STOP_COUNT && div_tick && !hit |=>
         cnt_ff == $past(cnt_ff) + 14'h0001;
   endproperty
   a_stop_count: assert property (p_stop_count)
      else $error("Counter missed a divided tick");

   property p_stop_resume;
      stop_done_evt |=> cpu_resume_out && cnt_ff == '0 ##1
         !cpu_resume_out && !stop_mode_out;
   endproperty
   a_stop_resume: assert property (p_stop_resume)
      else $error("Resume not a single pulse after match");

   // Seven of every eight ticks must leave the counter alone
   property p_div8;
      counting && src_tick && div_sel_ff == 2'h3 && div_ff != 3'h7 &&
         !hit && !abort && !sw_start |=> $stable(cnt_ff);
   endproperty
   a_div8: assert property (p_div8)
      else $error("Divide by eight tick misplaced");

   property p_hold;
      state_ff == warmup_pkg::ST_STOP_HOLD |=> $stable(cnt_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Counter moved during STOP");

   property p_sw_source;
      state_ff == warmup_pkg::ST_SW_COUNT |-> src_sel == src_sel_ff;
   endproperty
   a_sw_source: assert property (p_sw_source)
      else $error("Software warm-up uses wrong source");

   property p_no_restart;
      state_ff == warmup_pkg::ST_IDLE && wr_sys2 && !stop_enter_in &&
         !sw_start |=> state_ff == warmup_pkg::ST_IDLE;
   endproperty
   a_no_restart: assert property (p_no_restart)
      else $error("Counter started without an enable edge");

   property p_sw_done;
      state_ff == warmup_pkg::ST_SW_COUNT && hit && !stop_enter_in |=>
         state_ff == warmup_pkg::ST_IDLE && cnt_ff == '0 &&
         irq_stat_ff[`WU_IRQ_SW_DONE_BIT];
   endproperty
   a_sw_done: assert property (p_sw_done)
      else $error("Match did not finish software warm-up");

   property p_abort;
      abort && state_ff == warmup_pkg::ST_SW_COUNT && !stop_enter_in |=>
         cnt_ff == '0 && state_ff == warmup_pkg::ST_IDLE &&
         $stable(hf_en_ff) && $stable(lf_en_ff);
   endproperty
   a_abort: assert property (p_abort)
      else $error("Abort did not clear or touched enables");

   cover property (state_ff == warmup_pkg::ST_SW_COUNT ##1 sw_done_evt);
   cover property (stop_done_evt && !sw_pend_ff);
   cover property (stop_done_evt && sw_pend_ff);
   cover property (abort && state_ff == warmup_pkg::ST_SW_COUNT);

endmodule // oscillator_warmup_counter

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "warmup_params.svh"

module testbench;
   // Clock, reset and design inputs
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [4:0] address = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic hf_clk = 1'b0;
   logic lf_clk = 1'b0;
   logic stop_enter = 1'b0;
   logic stop_release = 1'b0;
   // Design outputs
   logic [31:0] rdata;
   logic waitreq, hf_run, lf_run, main_lf, stop_mode, resume, irq;
   // Bookkeeping
   int fails = 0;
   int n_checks = 0;
   logic [31:0] q, a;
   int n;
   logic [1:0] hf_cnt = 2'h0;
   int lf_cnt = 0;

   // 20 MHz system clock
   always #25 clk_sys_in = ~clk_sys_in;

   // Oscillators: high at 4 cycles, low at 6, both below clk/2
   always @(posedge clk_sys_in) begin
      hf_cnt <= hf_cnt + 2'h1;
      hf_clk <= hf_cnt[1];
      lf_cnt <= (lf_cnt == 5) ? 0 : lf_cnt + 1;
      lf_clk <= (lf_cnt < 3);
   end

   oscillator_warmup_counter DUT (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .high_freq_clock_in(hf_clk), .low_freq_clock_in(lf_clk),
      .stop_enter_in(stop_enter), .stop_release_in(stop_release),
      .hf_osc_run_out(hf_run), .lf_osc_run_out(lf_run),
      .main_clock_lf_out(main_lf), .stop_mode_out(stop_mode),
      .cpu_resume_out(resume), .warmup_done_interrupt_out(irq)
   );

   // Verdict, single exit point
   task automatic final_report();
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Duration lies near its ideal, allowing tick phase slack
   task automatic chk_time(input int got, input int exp);
      n_checks++;
      if (got < exp - exp / 8 || got > exp + 16) begin
         fails++;
         $display("CHECK FAILED %0t took %0d cycles, ideal %0d", $time, got,
            exp);
      end
   endtask

   // One Avalon cycle; held until waitrequest is sampled low
   task automatic xfer(input logic w, input logic [4:0] ad,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys_in);
      address <= ad;
      wdata <= d;
      rd <= !w;
      wr <= w;
      // Reads right after the edge see the values sampled at it;
      // only the watchdog ends a wait that never answers
      do begin
         @(posedge clk_sys_in);
      end while (waitreq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [4:0] ad, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, ad, d, r);
   endtask

   task automatic rd_chk(input logic [4:0] ad, input logic [31:0] exp);
      xfer(1'b0, ad, 32'h0, q);
      chk(q, exp);
   endtask

   // Cycles until irq (sel 0) or resume (sel 1) is seen high
   task automatic wait_for(input int sel, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk_sys_in);
         cnt++;
      end while (((sel == 0) ? irq : resume) !== 1'b1 && cnt < 5000);
   endtask

   // One-cycle power-mode pulse
   task automatic pulse(input int sel);
      @(posedge clk_sys_in);
      if (sel == 0) stop_enter <= 1'b1;
      else stop_release <= 1'b1;
      @(posedge clk_sys_in);
      stop_enter <= 1'b0;
      stop_release <= 1'b0;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_sys_in);
   endtask

   // Hang guard, far beyond the expected run length
   initial begin
      idle(60000);
      fails++;
      final_report();
   end

   initial begin
      idle(5);
      rst_n_in <= 1'b1;
      idle(1);
      // Reset values and an unmapped place
      rd_chk(`WU_OFS_CTRL, 32'h6);
      rd_chk(`WU_OFS_TIME, 32'h66);
      rd_chk(`WU_OFS_SYS2, 32'h1);
      rd_chk(`WU_OFS_STATUS, 32'h0);
      rd_chk(5'h18, 32'h0);
      // High oscillator enabled out of reset
      chk(hf_run, 1'b1);
      wr_reg(`WU_OFS_IRQ_MASK, 32'h3);
      wr_reg(`WU_OFS_TIME, 32'h1);
      // Every divide code on the high source, setting 1 = 64 inputs
      for (int d = 0; d < 4; d++) begin
         wr_reg(`WU_OFS_CTRL, 32'(d << 1));
         wr_reg(`WU_OFS_SYS2, 32'h0);
         wr_reg(`WU_OFS_SYS2, 32'h1);
         wait_for(0, n);
         chk_time(n, 256 << d);
         rd_chk(`WU_OFS_IRQ_STAT, 32'h1);
         rd_chk(`WU_OFS_STATUS, 32'h0);
         wr_reg(`WU_OFS_IRQ_STAT, 32'h3);
         idle(2);
         chk(irq, 1'b0);
      end
      // Low source selected: six-cycle oscillator
      wr_reg(`WU_OFS_CTRL, 32'h1);
      wr_reg(`WU_OFS_SYS2, 32'h3);
      wait_for(0, n);
      chk_time(n, 384);
      wr_reg(`WU_OFS_IRQ_STAT, 32'h3);
      // Rewriting a set enable must not restart
      wr_reg(`WU_OFS_SYS2, 32'h3);
      idle(20);
      rd_chk(`WU_OFS_STATUS, 32'h0);
      // Abort twice, rearming by a clear in between
      wr_reg(`WU_OFS_TIME, 32'h66);
      for (int i = 0; i < 2; i++) begin
         wr_reg(`WU_OFS_SYS2, 32'h1);
         wr_reg(`WU_OFS_SYS2, 32'h3);
         idle(30);
         xfer(1'b0, `WU_OFS_STATUS, 32'h0, q);
         chk(q[`WU_STAT_SW_BIT], 1'b1);
         wr_reg(`WU_OFS_CTRL, 32'h8);
         rd_chk(`WU_OFS_CTRL, 32'h0);
         rd_chk(`WU_OFS_STATUS, 32'h0);
         rd_chk(`WU_OFS_SYS2, 32'h3);
         rd_chk(`WU_OFS_IRQ_STAT, 32'h0);
      end
      // STOP with main clock from low osc, select says high
      wr_reg(`WU_OFS_TIME, 32'h1);
      wr_reg(`WU_OFS_SYS2, 32'h7);
      // The write lands on the edge the task returns on
      idle(1);
      chk(main_lf, 1'b1);
      pulse(0);
      idle(2);
      chk(stop_mode, 1'b1);
      chk(lf_run, 1'b0);
      chk(hf_run, 1'b0);
      pulse(1);
      wait_for(1, n);
      chk_time(n, 384);
      // Resume stands to the next edge; look one edge later
      idle(2);
      chk(stop_mode, 1'b0);
      chk(resume, 1'b0);
      rd_chk(`WU_OFS_IRQ_STAT, 32'h2);
      wr_reg(`WU_OFS_IRQ_STAT, 32'h3);
      // STOP in mid software warm-up holds the count
      wr_reg(`WU_OFS_SYS2, 32'h1);
      wr_reg(`WU_OFS_SYS2, 32'h3);
      idle(40);
      pulse(0);
      idle(4);
      xfer(1'b0, `WU_OFS_STATUS, 32'h0, a);
      idle(60);
      rd_chk(`WU_OFS_STATUS, a);
      chk(a[`WU_STAT_SW_BIT], 1'b1);
      chk(a[`WU_STAT_STOP_BIT], 1'b1);
      pulse(1);
      wait_for(1, n);
      chk(resume, 1'b1);
      idle(2);
      rd_chk(`WU_OFS_IRQ_STAT, 32'h3);
      final_report();
   end
endmodule // testbench
